// file: hw/gpp_pkg.sv
// constants and state type for the general purpose ports e to h
// assumes one system clock and a byte-wide register port
package gpp_pkg;

   // *******************************
   // port widths
   // *******************************
   localparam int unsigned E_W    = 8;
   localparam int unsigned F_W    = 7;
   localparam int unsigned G_W    = 3;
   localparam int unsigned H_W    = 2;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   // *******************************
   // register offsets
   // *******************************
   localparam logic [7:0] OFS_LAT_E = 8'h08;
   localparam logic [7:0] OFS_LAT_F = 8'h09;
   localparam logic [7:0] OFS_LAT_G = 8'h0a;
   localparam logic [7:0] OFS_LAT_H = 8'h0b;
   localparam logic [7:0] OFS_DIR_E = 8'h0c;
   localparam logic [7:0] OFS_DIR_F = 8'h0d;
   localparam logic [7:0] OFS_DIR_G = 8'h0e;
   localparam logic [7:0] OFS_DIR_H = 8'h0f;

   // *******************************
   // reset values
   // *******************************
   localparam logic [7:0] DIR_E_RST = 8'h00;
   localparam logic [6:0] DIR_F_RST = 7'h00;
   localparam logic [2:0] DIR_G_RST = 3'h0;
   localparam logic [1:0] DIR_H_RST = 2'h0;

   // *******************************
   // field positions and encodings
   // *******************************
   localparam int unsigned TA_CH    = 6;
   localparam int unsigned TB_CH    = 2;
   localparam int unsigned KPD_W    = 5;
   localparam int unsigned E_TX_BIT = 0;
   localparam int unsigned E_RX_BIT = 1;
   localparam logic [1:0]  ELS_GPIO = 2'h0;
   localparam int unsigned SYNC_STAGES = 2;

   typedef struct packed {
      logic [7:0] dir_e;
      logic [6:0] dir_f;
      logic [2:0] dir_g;
      logic [1:0] dir_h;
      logic [7:0] lat_e;
      logic [6:0] lat_f;
      logic [2:0] lat_g;
      logic [1:0] lat_h;
      logic [7:0] oe_e;
      logic [6:0] oe_f;
      logic [2:0] oe_g;
      logic [1:0] oe_h;
      logic [7:0] out_e;
      logic [6:0] out_f;
      logic [2:0] out_g;
      logic [1:0] out_h;
      logic [7:0] rd_data;
   } gpp_state_t;

endpackage : gpp_pkg

// file: hw/gpp_sync.sv
// two-stage synchroniser for a bundle of pin levels
// assumes the pins are asynchronous to sys_clk
`timescale 1ns/1ps
module gpp_sync #(
   parameter int unsigned W = 8
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         nrst,
   // pins in, levels out
   input  wire logic [W-1:0] pin_async,
   output logic      [W-1:0] pin_sync
);
   import gpp_pkg::*;

   logic [SYNC_STAGES-1:0][W-1:0] st_reg;
   logic [SYNC_STAGES-1:0][W-1:0] st_next;

   always_comb begin
      st_next = {st_reg[0], pin_async};
      if (!nrst) begin
         st_next = '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      st_reg <= st_next;
   end

   // only the second stage leaves this module
   assign pin_sync = st_reg[SYNC_STAGES-1];

endmodule : gpp_sync

// file: hw/gpp_port_slice.sv
// pin driver choice and read-back mux of one port
// assumes pin levels are already synchronised
`timescale 1ns/1ps
module gpp_port_slice #(
   parameter int unsigned W = 8
) (
   // software view
   input  wire logic [W-1:0] dir,
   input  wire logic [W-1:0] latch,
   input  wire logic [W-1:0] pin_level,
   // claim by a peripheral
   input  wire logic [W-1:0] own,
   input  wire logic [W-1:0] own_oe,
   input  wire logic [W-1:0] own_out,
   // results
   output logic      [W-1:0] oe_next,
   output logic      [W-1:0] out_next,
   output logic      [W-1:0] rd_value
);

   always_comb begin
      // a claimed pin follows its peripheral, else the direction bit
      oe_next  = (own & own_oe) | (~own & dir);
      out_next = (own & own_out) | (~own & latch);
      // direction bit always picks latch or pin for reads
      rd_value = (dir & latch) | (~dir & pin_level);
   end

endmodule : gpp_port_slice

// file: hw/gpp_ports.sv
// general purpose ports e, f, g and h with direction registers
// assumes peripheral claim signals arrive on sys_clk; pins are asynchronous
`timescale 1ns/1ps

// How it works
// - port e pins 3,2 become timer channel pins when their select field is nonzero.
// - timer-owned port e pin ignores direction for driving; direction still picks read source.
// - serial enable makes e1 receive input and e0 transmit output.
// - serial-owned port e pin ignores direction for driving; direction still picks read.
// - direction 1 enables the pin driver, 0 leaves the pin floating.
// - reset clears all direction bits, so every pin starts as input.
// - port e data read gives latch where direction set, pin otherwise.
// - port f data read gives latch where direction set, pin otherwise.
// - port g data read gives latch where direction set, pin otherwise.
// - port h data read gives latch where direction set, pin otherwise.
// - data writes always update the latch regardless of direction.
// - reset leaves the data latches untouched.
// - port f pins 3..0 serve timer a channels 5..2 when selected.
// - port f pins 5,4 serve timer b channels 1,0 when selected.
// - timer-owned port f pin ignores direction for driving; direction still picks read.
// - keypad enable on a port g pin makes it an input, overriding direction.
// - keypad enables 4,3 make the port h pins inputs.
module gpp_ports (
   // clock and reset
   input  wire logic                          sys_clk,
   input  wire logic                          nrst,
   // register port
   input  wire logic [gpp_pkg::ADDR_W-1:0]    reg_addr,
   input  wire logic [gpp_pkg::DATA_W-1:0]    reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [gpp_pkg::DATA_W-1:0]    reg_rdata,
   // timer units
   input  wire logic [2*gpp_pkg::TA_CH-1:0]   timer_unit_a_edge_level_select_field,
   input  wire logic [gpp_pkg::TA_CH-1:0]     timer_unit_a_ch_drive,
   input  wire logic [gpp_pkg::TA_CH-1:0]     timer_unit_a_ch_out,
   input  wire logic [2*gpp_pkg::TB_CH-1:0]   timer_unit_b_edge_level_select_field,
   input  wire logic [gpp_pkg::TB_CH-1:0]     timer_unit_b_ch_drive,
   input  wire logic [gpp_pkg::TB_CH-1:0]     timer_unit_b_ch_out,
   output logic      [gpp_pkg::TA_CH-1:0]     timer_a_channel_pins,
   output logic      [gpp_pkg::TB_CH-1:0]     timer_b_channel_pins,
   // serial unit
   input  wire logic                          serial_if_enable,
   input  wire logic                          serial_tx,
   output logic                               serial_rx,
   // keypad unit
   input  wire logic [gpp_pkg::KPD_W-1:0]     keypad_irq_enable,
   output logic      [gpp_pkg::KPD_W-1:0]     keypad_wake_pins,
   // port e pins
   input  wire logic [gpp_pkg::E_W-1:0]       pte_in,
   output logic      [gpp_pkg::E_W-1:0]       pte_out,
   output logic      [gpp_pkg::E_W-1:0]       pte_oe,
   // port f pins
   input  wire logic [gpp_pkg::F_W-1:0]       ptf_in,
   output logic      [gpp_pkg::F_W-1:0]       ptf_out,
   output logic      [gpp_pkg::F_W-1:0]       ptf_oe,
   // port g pins
   input  wire logic [gpp_pkg::G_W-1:0]       ptg_in,
   output logic      [gpp_pkg::G_W-1:0]       ptg_out,
   output logic      [gpp_pkg::G_W-1:0]       ptg_oe,
   // port h pins
   input  wire logic [gpp_pkg::H_W-1:0]       pth_in,
   output logic      [gpp_pkg::H_W-1:0]       pth_out,
   output logic      [gpp_pkg::H_W-1:0]       pth_oe
);
   import gpp_pkg::*;

   // ******************************************
   // pin synchronisers
   // ******************************************
   logic [E_W-1:0] e_lvl;
   logic [F_W-1:0] f_lvl;
   logic [G_W-1:0] g_lvl;
   logic [H_W-1:0] h_lvl;

   gpp_sync #(.W(E_W)) u_sync_e (.sys_clk(sys_clk), .nrst(nrst), .pin_async(pte_in), .pin_sync(e_lvl));
   gpp_sync #(.W(F_W)) u_sync_f (.sys_clk(sys_clk), .nrst(nrst), .pin_async(ptf_in), .pin_sync(f_lvl));
   gpp_sync #(.W(G_W)) u_sync_g (.sys_clk(sys_clk), .nrst(nrst), .pin_async(ptg_in), .pin_sync(g_lvl));
   gpp_sync #(.W(H_W)) u_sync_h (.sys_clk(sys_clk), .nrst(nrst), .pin_async(pth_in), .pin_sync(h_lvl));

   // ******************************************
   // peripheral claims
   // ******************************************
   gpp_state_t       st_reg;
   gpp_state_t       st_next;
   logic [TA_CH-1:0] ta_own;
   logic [TB_CH-1:0] tb_own;
   logic [E_W-1:0]   own_e;
   logic [E_W-1:0]   own_oe_e;
   logic [E_W-1:0]   own_out_e;
   logic [F_W-1:0]   own_f;
   logic [F_W-1:0]   own_oe_f;
   logic [F_W-1:0]   own_out_f;

   always_comb begin
      for (int i = 0; i < TA_CH; i++) begin
         ta_own[i] = (timer_unit_a_edge_level_select_field[2*i +: 2] != ELS_GPIO);
      end
      for (int j = 0; j < TB_CH; j++) begin
         tb_own[j] = (timer_unit_b_edge_level_select_field[2*j +: 2] != ELS_GPIO);
      end
      // e3,e2 timer a ch1,ch0; e1 receive; e0 transmit
      own_e     = {4'h0, ta_own[1:0], serial_if_enable, serial_if_enable};
      own_oe_e  = {4'h0, timer_unit_a_ch_drive[1:0], 1'b0, 1'b1};
      own_out_e = {4'h0, timer_unit_a_ch_out[1:0], 1'b0, serial_tx};
      // f5,f4 timer b ch1,ch0; f3..f0 timer a ch5..ch2
      own_f     = {1'b0, tb_own, ta_own[5:2]};
      own_oe_f  = {1'b0, timer_unit_b_ch_drive, timer_unit_a_ch_drive[5:2]};
      own_out_f = {1'b0, timer_unit_b_ch_out, timer_unit_a_ch_out[5:2]};
   end

   // ******************************************
   // per-port driver and read-back
   // ******************************************
   logic [E_W-1:0] oe_e_n;
   logic [E_W-1:0] out_e_n;
   logic [E_W-1:0] rd_e;
   logic [F_W-1:0] oe_f_n;
   logic [F_W-1:0] out_f_n;
   logic [F_W-1:0] rd_f;
   logic [G_W-1:0] oe_g_n;
   logic [G_W-1:0] out_g_n;
   logic [G_W-1:0] rd_g;
   logic [H_W-1:0] oe_h_n;
   logic [H_W-1:0] out_h_n;
   logic [H_W-1:0] rd_h;

   gpp_port_slice #(.W(E_W)) u_port_e (
      .dir(st_reg.dir_e), .latch(st_reg.lat_e), .pin_level(e_lvl),
      .own(own_e), .own_oe(own_oe_e), .own_out(own_out_e),
      .oe_next(oe_e_n), .out_next(out_e_n), .rd_value(rd_e));
   gpp_port_slice #(.W(F_W)) u_port_f (
      .dir(st_reg.dir_f), .latch(st_reg.lat_f), .pin_level(f_lvl),
      .own(own_f), .own_oe(own_oe_f), .own_out(own_out_f),
      .oe_next(oe_f_n), .out_next(out_f_n), .rd_value(rd_f));
   // keypad claim is input only: driver off, direction overridden
   gpp_port_slice #(.W(G_W)) u_port_g (
      .dir(st_reg.dir_g), .latch(st_reg.lat_g), .pin_level(g_lvl),
      .own(keypad_irq_enable[2:0]), .own_oe(3'h0), .own_out(3'h0),
      .oe_next(oe_g_n), .out_next(out_g_n), .rd_value(rd_g));
   gpp_port_slice #(.W(H_W)) u_port_h (
      .dir(st_reg.dir_h), .latch(st_reg.lat_h), .pin_level(h_lvl),
      .own(keypad_irq_enable[4:3]), .own_oe(2'h0), .own_out(2'h0),
      .oe_next(oe_h_n), .out_next(out_h_n), .rd_value(rd_h));

   // ******************************************
   // register file and pin registers
   // ******************************************
   always_comb begin
      st_next       = st_reg;
      st_next.oe_e  = oe_e_n;
      st_next.oe_f  = oe_f_n;
      st_next.oe_g  = oe_g_n;
      st_next.oe_h  = oe_h_n;
      st_next.out_e = out_e_n;
      st_next.out_f = out_f_n;
      st_next.out_g = out_g_n;
      st_next.out_h = out_h_n;
      st_next.rd_data = '0;
      if (reg_wr) begin
         case (reg_addr)
            OFS_LAT_E: st_next.lat_e = reg_wdata[E_W-1:0];
            OFS_LAT_F: st_next.lat_f = reg_wdata[F_W-1:0];
            OFS_LAT_G: st_next.lat_g = reg_wdata[G_W-1:0];
            OFS_LAT_H: st_next.lat_h = reg_wdata[H_W-1:0];
            OFS_DIR_E: st_next.dir_e = reg_wdata[E_W-1:0];
            OFS_DIR_F: st_next.dir_f = reg_wdata[F_W-1:0];
            OFS_DIR_G: st_next.dir_g = reg_wdata[G_W-1:0];
            OFS_DIR_H: st_next.dir_h = reg_wdata[H_W-1:0];
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            OFS_LAT_E: st_next.rd_data = rd_e;
            OFS_LAT_F: st_next.rd_data = {1'b0, rd_f};
            OFS_LAT_G: st_next.rd_data = {5'h00, rd_g};
            OFS_LAT_H: st_next.rd_data = {6'h00, rd_h};
            OFS_DIR_E: st_next.rd_data = st_reg.dir_e;
            OFS_DIR_F: st_next.rd_data = {1'b0, st_reg.dir_f};
            OFS_DIR_G: st_next.rd_data = {5'h00, st_reg.dir_g};
            OFS_DIR_H: st_next.rd_data = {6'h00, st_reg.dir_h};
            default:   st_next.rd_data = '0;
         endcase
      end
      if (!nrst) begin
         // latches keep their contents through reset
         st_next.dir_e   = DIR_E_RST;
         st_next.dir_f   = DIR_F_RST;
         st_next.dir_g   = DIR_G_RST;
         st_next.dir_h   = DIR_H_RST;
         st_next.oe_e    = '0;
         st_next.oe_f    = '0;
         st_next.oe_g    = '0;
         st_next.oe_h    = '0;
         st_next.rd_data = '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      st_reg <= st_next;
   end

   // ******************************************
   // outputs
   // ******************************************
   assign reg_rdata            = st_reg.rd_data;
   assign pte_out              = st_reg.out_e;
   assign pte_oe               = st_reg.oe_e;
   assign ptf_out              = st_reg.out_f;
   assign ptf_oe               = st_reg.oe_f;
   assign ptg_out              = st_reg.out_g;
   assign ptg_oe               = st_reg.oe_g;
   assign pth_out              = st_reg.out_h;
   assign pth_oe               = st_reg.oe_h;
   assign serial_rx            = e_lvl[E_RX_BIT];
   assign timer_a_channel_pins = {f_lvl[3:0], e_lvl[3:2]};
   assign timer_b_channel_pins = f_lvl[5:4];
   assign keypad_wake_pins     = {h_lvl, g_lvl};

   // ******************************************
   // assertions
   // ******************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   a_dir_reset: assert property (disable iff (1'b0) !nrst |=> (st_reg.dir_e == '0 && st_reg.dir_f == '0
      && st_reg.dir_g == '0 && st_reg.dir_h == '0 && pte_oe == '0)) else $error("direction not cleared");
   // checked on the first reset cycle only, so latches never written since power-up are not compared
   a_latch_keep: assert property (disable iff (1'b0) !nrst && $past(nrst) |=> (st_reg.lat_f == $past(st_reg.lat_f)
      && st_reg.lat_h == $past(st_reg.lat_h))) else $error("latch changed by reset");
   a_read_port_e: assert property (reg_rd && reg_addr == OFS_LAT_E |=> reg_rdata
      == $past((st_reg.dir_e & st_reg.lat_e) | (~st_reg.dir_e & e_lvl))) else $error("port e read wrong");
   a_read_port_f: assert property (reg_rd && reg_addr == OFS_LAT_F |=> reg_rdata[F_W-1:0]
      == $past((st_reg.dir_f & st_reg.lat_f) | (~st_reg.dir_f & f_lvl))) else $error("port f read wrong");
   a_read_port_g: assert property (reg_rd && reg_addr == OFS_LAT_G |=> reg_rdata
      == {5'h00, $past((st_reg.dir_g & st_reg.lat_g) | (~st_reg.dir_g & g_lvl))}) else $error("port g read wrong");
   a_read_port_h: assert property (reg_rd && reg_addr == OFS_LAT_H |=> reg_rdata
      == {6'h00, $past((st_reg.dir_h & st_reg.lat_h) | (~st_reg.dir_h & h_lvl))}) else $error("port h read wrong");
   a_write_latch: assert property (reg_wr && reg_addr == OFS_LAT_G |=> ##1 ptg_out[0] == $past(reg_wdata[0], 2)
      || keypad_irq_enable[0] || $past(keypad_irq_enable[0])) else $error("latch write lost");
   a_gpio_driver: assert property (!keypad_irq_enable[3] && st_reg.dir_h[0] |=> pth_oe[0] && pth_out[0] == $past(st_reg.lat_h[0]))
      else $error("gpio driver wrong");
   a_serial_pins: assert property (serial_if_enable |=> pte_oe[E_TX_BIT] && !pte_oe[E_RX_BIT]
      && pte_out[E_TX_BIT] == $past(serial_tx)) else $error("serial pins not taken");
   a_timer_e_pin: assert property (timer_unit_a_edge_level_select_field[1:0] != ELS_GPIO |=> pte_oe[2] == $past(timer_unit_a_ch_drive[0]))
      else $error("timer e pin wrong");
   a_timer_f_pin: assert property (timer_unit_b_edge_level_select_field[1:0] != ELS_GPIO |=> ptf_oe[4] == $past(timer_unit_b_ch_drive[0]))
      else $error("timer b pin wrong");
   a_timer_a_f: assert property (timer_unit_a_edge_level_select_field[11:10] != ELS_GPIO |=> ptf_out[3] == $past(timer_unit_a_ch_out[5]))
      else $error("timer a f pin wrong");
   a_keypad_g: assert property (keypad_irq_enable[0] |=> !ptg_oe[0]) else $error("keypad g pin driven");
   a_keypad_h: assert property (keypad_irq_enable[4] |=> !pth_oe[1]) else $error("keypad h pin driven");

   c_serial_on:  cover property (serial_if_enable && st_reg.dir_e[0] == 1'b0 ##1 pte_oe[0]);
   c_dir_read:   cover property (reg_wr && reg_addr == OFS_DIR_F ##1 reg_rd && reg_addr == OFS_LAT_F);
   c_kpd_over:   cover property (st_reg.dir_g[1] && keypad_irq_enable[1]);
   c_timer_own:  cover property (ta_own[3] && st_reg.dir_f[1] == 1'b0 ##1 ptf_oe[1]);

endmodule : gpp_ports

// file: verification/gpp_pin_env.sv
// partner: the board wiring at one port, resolving each pad level
// assumes an outside source drives every pad that the block leaves floating
`timescale 1ns/1ps
module gpp_pin_env #(
   parameter int unsigned W = 8
) (
   // block side
   input  wire logic [W-1:0] oe,
   input  wire logic [W-1:0] out,
   // outside source
   input  wire logic [W-1:0] ext,
   // pad level
   output logic      [W-1:0] lvl
);
   // ****************
   // pad resolution
   // ****************
   // a pad follows the block only while its driver is on
   assign lvl = (oe & out) | (~oe & ext);
endmodule : gpp_pin_env

// file: verification/gpp_ports_test.sv
// testbench: random register, pin and claim traffic on ports e to h
// assumes gpp_pkg, gpp_ports and gpp_pin_env are compiled first
`timescale 1ns/1ps
module gpp_ports_test;
   import gpp_pkg::*;
   // ****************
   // signals
   // ****************
   logic        sys_clk;
   logic        nrst;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   wire  [7:0]  reg_rdata;
   logic [11:0] tsa;
   logic [5:0]  tda, toa;
   wire  [5:0]  tap;
   logic [3:0]  tsb;
   logic [1:0]  tdb, tob;
   wire  [1:0]  tbp;
   logic        sen, stx;
   wire         srx;
   logic [4:0]  kp;
   wire  [4:0]  kwp;
   wire  [31:0] pin_in, pin_out, pin_oe;
   logic [31:0] pin_ext, seed, r;
   logic [7:0]  lat [4], dir [4], ext [4], own [4], ooe [4], oout [4], eo [4], eu [4], lvl [4];
   logic [7:0]  msk [4] = '{8'hff, 8'h7f, 8'h07, 8'h03};
   logic [7:0]  exp_q [$];
   logic        rd_seen;
   int          num_errors, checks_done;

   gpp_ports uut (
      .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_unit_a_edge_level_select_field(tsa), .timer_unit_a_ch_drive(tda),
      .timer_unit_a_ch_out(toa), .timer_unit_b_edge_level_select_field(tsb), .timer_unit_b_ch_drive(tdb), .timer_unit_b_ch_out(tob),
      .timer_a_channel_pins(tap), .timer_b_channel_pins(tbp), .serial_if_enable(sen), .serial_tx(stx),
      .serial_rx(srx), .keypad_irq_enable(kp), .keypad_wake_pins(kwp),
      .pte_in(pin_in[7:0]), .pte_out(pin_out[7:0]), .pte_oe(pin_oe[7:0]),
      .ptf_in(pin_in[14:8]), .ptf_out(pin_out[14:8]), .ptf_oe(pin_oe[14:8]),
      .ptg_in(pin_in[18:16]), .ptg_out(pin_out[18:16]), .ptg_oe(pin_oe[18:16]),
      .pth_in(pin_in[25:24]), .pth_out(pin_out[25:24]), .pth_oe(pin_oe[25:24]));

   for (genvar p = 0; p < 4; p++) begin : g_pad
      gpp_pin_env #(.W(8)) u_pad (.oe(pin_oe[8*p+:8]), .out(pin_out[8*p+:8]), .ext(pin_ext[8*p+:8]),
                                  .lvl(pin_in[8*p+:8]));
   end

   // ****************
   // helpers
   // ****************
   always #12.5 sys_clk = ~sys_clk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic fail(input string what, input logic [7:0] got, input logic [7:0] exp);
      num_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
   endtask : fail

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks_done++;
      if (got !== exp) fail(what, got, exp);
   endtask : chk

   task automatic chk_rd;
      logic [7:0] e;
      checks_done++;
      e = (exp_q.size() == 0) ? 8'hxx : exp_q.pop_front();
      if (reg_rdata !== e) fail("read", reg_rdata, e);
   endtask : chk_rd

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
   endtask : rd

   // read data stand only in the cycle after the strobe
   always @(posedge sys_clk) rd_seen <= reg_rd;
   always @(negedge sys_clk) begin
      if (rd_seen === 1'b1) chk_rd();
   end

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test

   // ****************
   // scenarios
   // ****************
   task automatic round;
      @(posedge sys_clk);
      r = rnd();
      tsa <= r[11:0];
      tda <= r[17:12];
      toa <= r[23:18];
      tsb <= r[27:24];
      tdb <= r[29:28];
      tob <= r[31:30];
      r = rnd();
      sen <= r[0];
      stx <= r[1];
      kp  <= r[6:2];
      pin_ext <= rnd();
      #1;
      own[0]  = {4'h0, |tsa[3:2], |tsa[1:0], sen, sen};
      ooe[0]  = {4'h0, tda[1:0], 2'b01};
      oout[0] = {4'h0, toa[1:0], 1'b0, stx};
      own[1]  = {2'b00, |tsb[3:2], |tsb[1:0], |tsa[11:10], |tsa[9:8], |tsa[7:6], |tsa[5:4]};
      ooe[1]  = {2'b00, tdb, tda[5:2]};
      oout[1] = {2'b00, tob, toa[5:2]};
      own[2]  = {5'h00, kp[2:0]};
      own[3]  = {6'h00, kp[4:3]};
      for (int p = 0; p < 4; p++) begin
         if (p > 1) ooe[p] = 8'h00;
         if (p > 1) oout[p] = 8'h00;
         r = rnd();
         lat[p] = r[7:0] & msk[p];
         dir[p] = r[15:8] & msk[p];
         ext[p] = pin_ext[8*p+:8] & msk[p];
         eo[p]  = ((own[p] & ooe[p]) | (~own[p] & dir[p])) & msk[p];
         eu[p]  = (own[p] & oout[p]) | (~own[p] & lat[p]);
         lvl[p] = (eo[p] & eu[p]) | (~eo[p] & ext[p]);
      end
      for (int p = 0; p < 4; p++) begin
         wr(OFS_LAT_E + 8'(p), lat[p]);
         wr(OFS_DIR_E + 8'(p), dir[p]);
      end
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      for (int p = 0; p < 4; p++) begin
         chk(pin_oe[8*p+:8] & msk[p], eo[p], "driver enable");
         chk(pin_out[8*p+:8] & eo[p], eu[p] & eo[p], "drive value");
      end
      chk({2'b00, tap}, {2'b00, lvl[1][3:0], lvl[0][3:2]}, "timer a pins");
      chk({6'h00, tbp}, {6'h00, lvl[1][5:4]}, "timer b pins");
      chk({7'h00, srx}, {7'h00, lvl[0][1]}, "serial receive");
      chk({3'h0, kwp}, {3'h0, lvl[3][1:0], lvl[2][2:0]}, "keypad pins");
      for (int p = 0; p < 4; p++) begin
         rd(OFS_LAT_E + 8'(p), (dir[p] & lat[p]) | (~dir[p] & lvl[p]));
         rd(OFS_DIR_E + 8'(p), dir[p]);
      end
   endtask : round

   initial begin
      sys_clk = 1'b0;
      nrst = 1'b0;
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      {tsa, tda, toa, tsb, tdb, tob, sen, stx, kp} = '0;
      pin_ext = '0;
      seed = 32'h1e34c694;
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      for (int p = 0; p < 4; p++) rd(OFS_DIR_E + 8'(p), 8'h00);
      wr(OFS_LAT_H, 8'h00);
      wr(OFS_DIR_H, 8'hff);
      rd(OFS_DIR_H, 8'h03);
      wr(8'h07, 8'hff);
      rd(8'h07, 8'h00);
      rd(8'h10, 8'h00);
      $display("test registers done");
      repeat (40) round();
      $display("test random traffic done");
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      for (int p = 0; p < 4; p++) chk(pin_oe[8*p+:8] & msk[p], 8'h00, "reset enable");
      @(posedge sys_clk);
      nrst <= 1'b1;
      for (int p = 0; p < 4; p++) rd(OFS_DIR_E + 8'(p), 8'h00);
      for (int p = 0; p < 4; p++) wr(OFS_DIR_E + 8'(p), msk[p]);
      for (int p = 0; p < 4; p++) rd(OFS_LAT_E + 8'(p), lat[p]);
      repeat (3) @(posedge sys_clk);
      $display("test latch across reset done");
      finish_test();
   end

   initial begin
      repeat (5000) @(posedge sys_clk);
      num_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      finish_test();
   end
endmodule : gpp_ports_test
